//--- core/ccs_status_counters.sv
// channel status word (low bits) and the two error counters, read through the management port
// assumes the management front end issues one-cycle read strobes with a register address,
// and that all event and level inputs are synchronous to clk; arst_n is the datapath reset
//
// What this block does
// - bit 8 sets on bad code word
// - bit 8 only meaningful while decoding/CRPAT
// - functional mode counts code violations at 0x10
// - bits 7/6: transmit FIFO underflow/overflow
// - bits 5/4: receive FIFO underflow/overflow
// - bit 3: system side link up, latched-low
// - bit 2: alignment slave sync and aligned
// - bit 1: slow side PLL locked
// - bit 0: fast side PLL locked
// - status register resets to zero
// - fast test mode counts selected pattern errors
// - PRBS pin selects PRBS bit error counting
// - counter read returns count, then clears
// - counters reset to 0xFFFD
// - lane 0 counts slave decoder code violations
// - slow test mode counts selected pattern errors
`timescale 1ns/1ps
`default_nettype none

module ccs_status_counters #(
    parameter int unsigned CNT_W = ccs_pkg::CNT_W
) (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          rd_stb,
    input  wire logic [ccs_pkg::ADDR_W-1:0]    rd_addr,
    output var  logic [ccs_pkg::DATA_W-1:0]    rd_data_q,
    output var  logic                          rd_ack_q,
    input  wire ccs_pkg::ccs_fast_in_t         fast_in,
    input  wire ccs_pkg::ccs_slow_in_t         slow_in,
    input  wire ccs_pkg::ccs_stat_in_t         stat_in
);

    if (CNT_W != ccs_pkg::DATA_W) begin : g_bad_cnt_w
        $error("ccs_status_counters: CNT_W must equal the register width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic pick_err(input logic [7:0] errs, input logic [2:0] sel);
        pick_err = errs[sel];
    endfunction

    logic                             rd_status;
    logic                             rd_fast;
    logic                             rd_slow;
    logic                             fast_inc;
    logic                             slow_inc;
    logic [ccs_pkg::STATUS_BITS-1:0]  status_live;
    logic [ccs_pkg::STATUS_BITS-1:0]  status_q;
    logic [CNT_W-1:0]                 fast_count_q;
    logic [CNT_W-1:0]                 slow_count_q;

    assign rd_status = rd_stb && (rd_addr == ccs_pkg::ADDR_STATUS);
    assign rd_fast   = rd_stb && (rd_addr == ccs_pkg::ADDR_FAST_COUNT);
    assign rd_slow   = rd_stb && (rd_addr == ccs_pkg::ADDR_SLOW_COUNT);

    ////////////////////////////////////////////////////////////////////////////
    // error sources

    always_comb begin
        if (fast_in.pseudo_random_check_pin) begin
            fast_inc = fast_in.prbs_bit_err;
        end else if (fast_in.test_mode) begin
            fast_inc = pick_err(fast_in.pattern_err, fast_in.pattern_sel);
        end else begin
            fast_inc = fast_in.code_violation;
        end
        if (slow_in.test_mode) begin
            slow_inc = pick_err({4'h0, slow_in.pattern_err}, {1'b0, slow_in.pattern_sel});
        end else begin
            slow_inc = slow_in.code_violation;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word

    always_comb begin
        // outside decoding or CRPAT checking the decoder flag is noise, so it is not latched
        status_live[ccs_pkg::BIT_CODE_VIOLATION] = fast_in.code_violation
            && (fast_in.decoder_enabled || fast_in.crpat_check_active);
        status_live[ccs_pkg::BIT_TX_UNDERFLOW] = stat_in.tx_underflow;
        status_live[ccs_pkg::BIT_TX_OVERFLOW]  = stat_in.tx_overflow;
        status_live[ccs_pkg::BIT_RX_UNDERFLOW] = stat_in.rx_underflow;
        status_live[ccs_pkg::BIT_RX_OVERFLOW]  = stat_in.rx_overflow;
        status_live[ccs_pkg::BIT_SYSTEM_LINK]  = stat_in.system_side_link_up;
        status_live[ccs_pkg::BIT_ALIGN_LINK]   = stat_in.alignment_slave_link_up;
        status_live[ccs_pkg::BIT_SLOW_PLL]     = stat_in.slow_side_pll_locked;
        status_live[ccs_pkg::BIT_FAST_PLL]     = stat_in.fast_side_pll_locked;
    end

    for (genvar i = 0; i < ccs_pkg::STATUS_BITS; i++) begin : g_status
        // each bit resets to zero and holds its latched level until read
        ccs_latch_bit #(
            .LATCH_HIGH (ccs_pkg::LATCH_HIGH_MASK[i])
        ) u_bit (
            .clk      (clk),
            .arst_n   (arst_n),
            .live     (status_live[i]),
            .read_stb (rd_status),
            .bit_q    (status_q[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // error counters

    ccs_sat_counter #(
        .W         (CNT_W),
        .RESET_VAL (ccs_pkg::COUNT_RESET)
    ) u_fast_count (
        .clk     (clk),
        .arst_n  (arst_n),
        .inc     (fast_inc),
        .clr     (rd_fast),
        .count_q (fast_count_q)
    );

    ccs_sat_counter #(
        .W         (CNT_W),
        .RESET_VAL (ccs_pkg::COUNT_RESET)
    ) u_slow_count (
        .clk     (clk),
        .arst_n  (arst_n),
        .inc     (slow_inc),
        .clr     (rd_slow),
        .count_q (slow_count_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read port

    logic [ccs_pkg::DATA_W-1:0] rd_data_d;
    logic                       rd_ack_d;

    always_comb begin
        rd_ack_d  = rd_stb;
        rd_data_d = ccs_pkg::STATUS_RESET;
        if (rd_status) begin
            rd_data_d = {{(ccs_pkg::DATA_W-ccs_pkg::STATUS_BITS){1'b0}}, status_q};
        end else if (rd_fast) begin
            rd_data_d = fast_count_q;
        end else if (rd_slow) begin
            rd_data_d = slow_count_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= ccs_pkg::STATUS_RESET;
            rd_ack_q  <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_ack_q  <= rd_ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_flag_sets;
        fast_in.code_violation && fast_in.decoder_enabled && !rd_status
            |=> status_q[ccs_pkg::BIT_CODE_VIOLATION];
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("decoder flag not set");

    property p_flag_gated;
        !status_q[ccs_pkg::BIT_CODE_VIOLATION] && !fast_in.decoder_enabled && !fast_in.crpat_check_active
            && !rd_status |=> !status_q[ccs_pkg::BIT_CODE_VIOLATION];
    endproperty
    a_flag_gated: assert property (p_flag_gated) else $error("decoder flag set while idle");

    property p_flag_crpat;
        fast_in.code_violation && fast_in.crpat_check_active && !rd_status
            |=> status_q[ccs_pkg::BIT_CODE_VIOLATION];
    endproperty
    a_flag_crpat: assert property (p_flag_crpat) else $error("decoder flag missed in pattern check");

    property p_fast_counts;
        !fast_in.pseudo_random_check_pin && !fast_in.test_mode && fast_in.code_violation
            && !rd_fast && fast_count_q != ccs_pkg::COUNT_MAX
            |=> fast_count_q == $past(fast_count_q) + ccs_pkg::COUNT_ONE;
    endproperty
    a_fast_counts: assert property (p_fast_counts) else $error("fast counter missed error");

    property p_tx_under;
        stat_in.tx_underflow |=> status_q[ccs_pkg::BIT_TX_UNDERFLOW];
    endproperty
    a_tx_under: assert property (p_tx_under) else $error("tx underflow not flagged");

    property p_rx_under;
        stat_in.rx_underflow |=> status_q[ccs_pkg::BIT_RX_UNDERFLOW];
    endproperty
    a_rx_under: assert property (p_rx_under) else $error("rx underflow not flagged");

    property p_rx_over;
        stat_in.rx_overflow ##1 !rd_status[*2] |=> status_q[ccs_pkg::BIT_RX_OVERFLOW];
    endproperty
    a_rx_over: assert property (p_rx_over) else $error("rx overflow flag lost");

    property p_link_low;
        !stat_in.system_side_link_up ##1 (!rd_status && stat_in.system_side_link_up)
            |=> !status_q[ccs_pkg::BIT_SYSTEM_LINK];
    endproperty
    a_link_low: assert property (p_link_low) else $error("link loss not held");

    property p_align_live;
        rd_status |=> status_q[ccs_pkg::BIT_ALIGN_LINK] == $past(stat_in.alignment_slave_link_up);
    endproperty
    a_align_live: assert property (p_align_live) else $error("alignment link bit wrong after read");

    property p_slow_pll;
        rd_status && stat_in.slow_side_pll_locked |=> status_q[ccs_pkg::BIT_SLOW_PLL];
    endproperty
    a_slow_pll: assert property (p_slow_pll) else $error("slow pll lock not shown");

    property p_fast_pll;
        rd_status && stat_in.fast_side_pll_locked |=> status_q[ccs_pkg::BIT_FAST_PLL];
    endproperty
    a_fast_pll: assert property (p_fast_pll) else $error("fast pll lock not shown");

    property p_lh_holds;
        status_q[ccs_pkg::BIT_TX_OVERFLOW] && !rd_status |=> status_q[ccs_pkg::BIT_TX_OVERFLOW];
    endproperty
    a_lh_holds: assert property (p_lh_holds) else $error("latched event lost before read");

    property p_status_read;
        rd_status |=> rd_data_q == {{(ccs_pkg::DATA_W-ccs_pkg::STATUS_BITS){1'b0}}, $past(status_q)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read data wrong");

    property p_read_clears;
        rd_fast && !fast_inc |=> rd_ack_q && rd_data_q == $past(fast_count_q)
            && fast_count_q == ccs_pkg::COUNT_ZERO;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not return and clear");

    property p_saturate;
        slow_count_q == ccs_pkg::COUNT_MAX && !rd_slow |=> slow_count_q == ccs_pkg::COUNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter wrapped");

    property p_prbs_counts;
        fast_in.pseudo_random_check_pin && fast_in.prbs_bit_err && !rd_fast
            && fast_count_q != ccs_pkg::COUNT_MAX
            |=> fast_count_q == $past(fast_count_q) + ccs_pkg::COUNT_ONE;
    endproperty
    a_prbs_counts: assert property (p_prbs_counts) else $error("prbs error not counted");

    property p_reset_values;
        $rose(arst_n) |-> {{(ccs_pkg::DATA_W-ccs_pkg::STATUS_BITS){1'b0}}, status_q} == ccs_pkg::STATUS_RESET
            && fast_count_q == ccs_pkg::COUNT_RESET && slow_count_q == ccs_pkg::COUNT_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("wrong values after reset");

    property p_ack_timing;
        rd_ack_q == $past(rd_stb);
    endproperty
    a_ack_timing: assert property (p_ack_timing) else $error("read answer not one cycle later");

    property p_slow_read_clears;
        rd_slow && !slow_inc |=> rd_ack_q && rd_data_q == $past(slow_count_q)
            && slow_count_q == ccs_pkg::COUNT_ZERO;
    endproperty
    a_slow_read_clears: assert property (p_slow_read_clears) else $error("slow read not cleared");

    property p_slow_counts;
        !slow_in.test_mode && slow_in.code_violation && !rd_slow && slow_count_q != ccs_pkg::COUNT_MAX
            |=> slow_count_q == $past(slow_count_q) + ccs_pkg::COUNT_ONE;
    endproperty
    a_slow_counts: assert property (p_slow_counts) else $error("slow counter missed error");

    property p_fast_pattern;
        !fast_in.pseudo_random_check_pin && fast_in.test_mode && !rd_fast && fast_count_q != ccs_pkg::COUNT_MAX
            |=> fast_count_q == $past(fast_count_q)
                + ($past(fast_in.pattern_err[fast_in.pattern_sel]) ? ccs_pkg::COUNT_ONE : ccs_pkg::COUNT_ZERO);
    endproperty
    a_fast_pattern: assert property (p_fast_pattern) else $error("fast pattern count wrong");

    property p_slow_pattern;
        slow_in.test_mode && !rd_slow && slow_count_q != ccs_pkg::COUNT_MAX
            |=> slow_count_q == $past(slow_count_q)
                + ($past(slow_in.pattern_err[slow_in.pattern_sel]) ? ccs_pkg::COUNT_ONE : ccs_pkg::COUNT_ZERO);
    endproperty
    a_slow_pattern: assert property (p_slow_pattern) else $error("slow pattern count wrong");

    property p_fast_saturate;
        fast_count_q == ccs_pkg::COUNT_MAX && !rd_fast |=> fast_count_q == ccs_pkg::COUNT_MAX;
    endproperty
    a_fast_saturate: assert property (p_fast_saturate) else $error("fast counter wrapped");

    c_fast_read:   cover property (rd_fast ##1 rd_data_q != ccs_pkg::COUNT_ZERO);
    c_saturated:   cover property (fast_count_q == ccs_pkg::COUNT_MAX);
    c_flag_read:   cover property (status_q[8] && rd_status);
    c_read_and_ev: cover property (rd_slow && slow_inc);

endmodule : ccs_status_counters

`default_nettype wire

//--- core/ccs_pkg.sv
// constants, field layouts and input bundles for the channel status and error counters
// assumes a management front end that turns host frames into single-cycle read strobes
package ccs_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W  = 16;

    // register offsets
    localparam logic [15:0] ADDR_STATUS     = 16'h000F;
    localparam logic [15:0] ADDR_FAST_COUNT = 16'h0010;
    localparam logic [15:0] ADDR_SLOW_COUNT = 16'h0011;

    // reset values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET  = 16'hFFFD;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE    = 16'h0001;
    localparam logic [15:0] COUNT_ZERO   = 16'h0000;

    // status field positions
    localparam int unsigned STATUS_BITS        = 9;
    localparam int unsigned BIT_CODE_VIOLATION = 8;
    localparam int unsigned BIT_TX_UNDERFLOW   = 7;
    localparam int unsigned BIT_TX_OVERFLOW    = 6;
    localparam int unsigned BIT_RX_UNDERFLOW   = 5;
    localparam int unsigned BIT_RX_OVERFLOW    = 4;
    localparam int unsigned BIT_SYSTEM_LINK    = 3;
    localparam int unsigned BIT_ALIGN_LINK     = 2;
    localparam int unsigned BIT_SLOW_PLL       = 1;
    localparam int unsigned BIT_FAST_PLL       = 0;

    // 1 = latched high (holds a one), 0 = latched low (holds a zero)
    localparam logic [8:0] LATCH_HIGH_MASK = 9'h1F0;

    typedef struct packed {
        logic       code_violation;
        logic       decoder_enabled;
        logic       crpat_check_active;
        logic       test_mode;
        logic [2:0] pattern_sel;
        logic [7:0] pattern_err;
        logic       pseudo_random_check_pin;
        logic       prbs_bit_err;
    } ccs_fast_in_t;

    typedef struct packed {
        logic       code_violation;
        logic       test_mode;
        logic [1:0] pattern_sel;
        logic [3:0] pattern_err;
    } ccs_slow_in_t;

    typedef struct packed {
        logic tx_underflow;
        logic tx_overflow;
        logic rx_underflow;
        logic rx_overflow;
        logic system_side_link_up;
        logic alignment_slave_link_up;
        logic slow_side_pll_locked;
        logic fast_side_pll_locked;
    } ccs_stat_in_t;

endpackage : ccs_pkg

//--- core/ccs_latch_bit.sv
// one latched status bit: latched high or latched low, refreshed by a read
// assumes read_stb is the single-cycle read of the register holding this bit
`timescale 1ns/1ps
`default_nettype none

module ccs_latch_bit #(
    parameter bit LATCH_HIGH = 1'b1
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic live,
    input  wire logic read_stb,
    output var  logic bit_q
);

    logic bit_d;

    // a read hands over to the live value, so an event in the read cycle is kept
    always_comb begin
        if (read_stb) begin
            bit_d = live;
        end else if (LATCH_HIGH) begin
            bit_d = bit_q | live;
        end else begin
            bit_d = bit_q & live;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_q <= 1'b0;
        end else begin
            bit_q <= bit_d;
        end
    end

endmodule : ccs_latch_bit

`default_nettype wire

//--- core/ccs_sat_counter.sv
// saturating error counter, cleared by a read
// assumes clr is the single-cycle read of this counter's register
`timescale 1ns/1ps
`default_nettype none

module ccs_sat_counter #(
    parameter int unsigned      W         = 16,
    parameter logic [W-1:0]     RESET_VAL = '1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         inc,
    input  wire logic         clr,
    output var  logic [W-1:0] count_q
);

    logic [W-1:0] count_d;

    if (W < 2) begin : g_bad_width
        $error("ccs_sat_counter: W must be at least 2");
    end

    always_comb begin
        if (clr) begin
            // an error seen in the read cycle starts the new count
            count_d = inc ? {{(W-1){1'b0}}, 1'b1} : '0;
        end else if (inc && (count_q != '1)) begin
            count_d = count_q + {{(W-1){1'b0}}, 1'b1};
        end else begin
            count_d = count_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= RESET_VAL;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : ccs_sat_counter

`default_nettype wire

//--- testbench/ccs_host_model.sv
// management host model: issues single-cycle register reads and collects the answer
// assumes the read port of ccs_status_counters and a free-running clk
`timescale 1ns/1ps
`default_nettype none

module ccs_host_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    output var  logic        rd_stb,
    output var  logic [15:0] rd_addr,
    input  wire logic [15:0] rd_data_q,
    input  wire logic        rd_ack_q
);
    initial begin
        rd_stb  = 1'b0;
        rd_addr = 16'h0000;
    end

    // call just after a rising edge; returns at the edge where the answer is sampled
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output int waits);
        int n;
        n = 1;
        rd_stb  <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_stb  <= 1'b0;
        // released address is scrambled so a stale one is never trusted
        rd_addr <= ~a;
        @(posedge clk);
        while (rd_ack_q !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        d = rd_data_q;
        waits = n;
    endtask
endmodule // ccs_host_model

`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for ccs_status_counters
// assumes the host model as read master; event and level inputs driven here
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
    logic                  clk;
    logic                  arst_n;
    logic                  rd_stb;
    logic [15:0]           rd_addr;
    logic [15:0]           rd_data_q;
    logic                  rd_ack_q;
    ccs_pkg::ccs_fast_in_t fin;
    ccs_pkg::ccs_slow_in_t sin;
    ccs_pkg::ccs_stat_in_t sti;
    int                    mismatches = 0;
    int                    tests_run = 0;
    int                    cycles = 0;
    logic [7:0]            stat_pat;

    ccs_status_counters dut (
        .clk(clk), .arst_n(arst_n), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
        .rd_ack_q(rd_ack_q), .fast_in(fin), .slow_in(sin), .stat_in(sti)
    );

    ccs_host_model host (
        .clk(clk), .arst_n(arst_n), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
        .rd_ack_q(rd_ack_q)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        int          w;
        host.rd(a, v, w);
        `CHK(v, exp)
        `CHK(w, 1)
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        arst_n = 1'b0;
        fin    = '0;
        sin    = '0;
        sti    = '0;
        hold(4);
        arst_n <= 1'b1;
        rdchk(ccs_pkg::ADDR_STATUS, ccs_pkg::STATUS_RESET);
        rdchk(ccs_pkg::ADDR_FAST_COUNT, ccs_pkg::COUNT_RESET);
        rdchk(ccs_pkg::ADDR_SLOW_COUNT, ccs_pkg::COUNT_RESET);
        rdchk(16'h0012, 16'h0000);
        // functional mode counting, then clear on read
        fin.code_violation <= 1'b1;
        sin.code_violation <= 1'b1;
        hold(5);
        fin.code_violation <= 1'b0;
        sin.code_violation <= 1'b0;
        rdchk(ccs_pkg::ADDR_FAST_COUNT, 16'h0005);
        rdchk(ccs_pkg::ADDR_SLOW_COUNT, 16'h0005);
        rdchk(ccs_pkg::ADDR_FAST_COUNT, ccs_pkg::COUNT_ZERO);
        // test pattern modes: unselected errors and code violations must not count
        fin.test_mode      <= 1'b1;
        sin.test_mode      <= 1'b1;
        fin.code_violation <= 1'b1;
        sin.code_violation <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            fin.pattern_sel <= 3'(s);
            sin.pattern_sel <= 2'(s);
            fin.pattern_err <= ~(8'h01 << s);
            sin.pattern_err <= ~(4'h1 << s[1:0]);
            hold(2);
            fin.pattern_err <= 8'h01 << s;
            sin.pattern_err <= 4'h1 << s[1:0];
            hold(s + 1);
            fin.pattern_err <= 8'h00;
            sin.pattern_err <= 4'h0;
            rdchk(ccs_pkg::ADDR_FAST_COUNT, 16'(s + 1));
            rdchk(ccs_pkg::ADDR_SLOW_COUNT, 16'(s + 1));
        end
        // pin overrides pattern selection
        fin.pseudo_random_check_pin <= 1'b1;
        fin.pattern_err             <= 8'hFF;
        hold(2);
        fin.prbs_bit_err <= 1'b1;
        hold(3);
        fin <= '0;
        sin <= '0;
        rdchk(ccs_pkg::ADDR_FAST_COUNT, 16'h0003);
        // status: levels up, then one event or one drop per bit
        sti <= ccs_pkg::ccs_stat_in_t'(8'h0F);
        hold(1);
        rdchk(ccs_pkg::ADDR_STATUS, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            stat_pat = (i >= 4) ? (8'h0F | (8'h01 << i)) : (8'h0F & ~(8'h01 << i));
            sti <= ccs_pkg::ccs_stat_in_t'(stat_pat);
            hold(1);
            // two quiet cycles show the latched level holding without a read
            sti <= ccs_pkg::ccs_stat_in_t'(8'h0F);
            hold(2);
            rdchk(ccs_pkg::ADDR_STATUS, {8'h00, stat_pat});
            rdchk(ccs_pkg::ADDR_STATUS, 16'h000F);
        end
        // decode flag gated by decoder or pattern check; counter is not
        for (int j = 0; j < 3; j++) begin
            fin.decoder_enabled    <= (j == 1);
            fin.crpat_check_active <= (j == 2);
            fin.code_violation     <= 1'b1;
            hold(1);
            fin.code_violation <= 1'b0;
            rdchk(ccs_pkg::ADDR_STATUS, (j != 0) ? 16'h010F : 16'h000F);
        end
        rdchk(ccs_pkg::ADDR_FAST_COUNT, 16'h0003);
        // second reset mid-run, then saturation from the reset value
        arst_n <= 1'b0;
        hold(2);
        arst_n <= 1'b1;
        rdchk(ccs_pkg::ADDR_STATUS, ccs_pkg::STATUS_RESET);
        fin.code_violation <= 1'b1;
        sin.code_violation <= 1'b1;
        hold(4);
        fin.code_violation <= 1'b0;
        sin.code_violation <= 1'b0;
        rdchk(ccs_pkg::ADDR_FAST_COUNT, ccs_pkg::COUNT_MAX);
        rdchk(ccs_pkg::ADDR_SLOW_COUNT, ccs_pkg::COUNT_MAX);
        close_out();
    end
endmodule // tb

`default_nettype wire
